/* File: dv/aotc_regs_tb_top.sv */
// Self-checking testbench of the trim and configuration register bank
`include "aotc_map.svh"

module aotc_regs_tb_top
	import aotc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        i_ref_clk = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        i_wr_en   = 1'b0;
	logic        i_rd_en   = 1'b0;
	logic [7:0]  i_addr    = 8'h00;
	logic [15:0] i_wr_data = 16'h0000;
	logic [15:0] o_rd_data;
	logic        o_rd_valid;
	logic        o_rd_hit;
	aotc_cfg_s   o_cfg;
	int          n_errors  = 0;
	int          n_tests   = 0;
	logic [16:0] exp_q [$];
	logic [15:0] mdl [7];
	// Offset, default and writable field mask of each register
	logic [7:0]  tab_addr [7] = '{`AOTC_ADDR_INTEG, `AOTC_ADDR_PATH, `AOTC_ADDR_REFBIAS,
		`AOTC_ADDR_LED, `AOTC_ADDR_SLOW_OSC, `AOTC_ADDR_FAST_BYP, `AOTC_ADDR_FAST_TRIM};
	logic [15:0] tab_rst [7] = '{`AOTC_RST_INTEG, `AOTC_RST_PATH, `AOTC_RST_REFBIAS,
		`AOTC_RST_LED, `AOTC_RST_SLOW_OSC, `AOTC_RST_FAST_BYP, `AOTC_RST_FAST_TRIM};
	logic [15:0] tab_mask [7] = '{16'h1F00, 16'hFFFF, 16'h0000, 16'h0F80, 16'h41BF,
		16'h0003, 16'h7FFF};

	aotc_regs DUT (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_wr_en(i_wr_en),
		.i_rd_en(i_rd_en), .i_addr(i_addr), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data),
		.o_rd_valid(o_rd_valid), .o_rd_hit(o_rd_hit), .o_cfg(o_cfg));

	// Clock of 8 ns
	initial begin
		forever #4 i_ref_clk = ~i_ref_clk;
	end

	function automatic int idx(input logic [7:0] a);
		idx = -1;
		for (int k = 0; k < 7; k++) if (tab_addr[k] == a) idx = k;
	endfunction

	task automatic chk_rd(input string what, input logic [16:0] e, input logic [16:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_cfg(input string what, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic end_of_test();
		if (n_errors == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// One access per cycle; strobes stay up for back-to-back calls
	task automatic acc(input logic wr, input logic rd, input logic [7:0] a,
		input logic [15:0] d);
		int k;
		k = idx(a);
		if (rd) exp_q.push_back((k < 0) ? 17'h0_0000 : {1'b1, mdl[k]});
		if (wr && k >= 0) mdl[k] = d;
		i_wr_en   <= wr;
		i_rd_en   <= rd;
		i_addr    <= a;
		i_wr_data <= d;
		@(posedge i_ref_clk);
	endtask

	task automatic idle();
		i_wr_en <= 1'b0;
		i_rd_en <= 1'b0;
		@(posedge i_ref_clk);
	endtask

	// Write random field values, reserved bits kept at default
	task automatic rnd_wr(input int k);
		acc(1'b1, 1'b0, tab_addr[k],
			(tab_rst[k] & ~tab_mask[k]) | (16'($urandom) & tab_mask[k]));
	endtask

	task automatic read_all();
		for (int k = 0; k < 7; k++) acc(1'b0, 1'b1, tab_addr[k], 16'h0000);
		idle();
	endtask

	task automatic do_reset();
		i_sys_rst <= 1'b1;
		repeat (5) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		for (int k = 0; k < 7; k++) mdl[k] = tab_rst[k];
	endtask

	// Read result checker, oldest expectation first
	always @(negedge i_ref_clk) begin
		if (o_rd_valid === 1'b1) begin
			if (exp_q.size() == 0) chk_rd("stray read", 17'h1_FFFF, {o_rd_hit, o_rd_data});
			else chk_rd("read", exp_q.pop_front(), {o_rd_hit, o_rd_data});
		end
	end

	// Main sequence
	initial begin
		logic [2:0] c;
		void'($urandom(28405));
		do_reset();
		read_all();
		@(negedge i_ref_clk);
		chk_cfg("path_mode", 16'(AOTC_PATH_MODE_FULL), 16'(o_cfg.path_mode));
		chk_cfg("power_n", 16'h0000, 16'(o_cfg.slow_osc_power_n));
		chk_cfg("ref_bias", `AOTC_RST_REFBIAS, o_cfg.reference_bias);
		for (int v = 0; v < 4; v++) begin
			c = 3'($urandom);
			acc(1'b1, 1'b0, `AOTC_ADDR_INTEG, 16'h0008 | {3'h0, c, 2'(v), 8'h00});
			idle();
			@(negedge i_ref_clk);
			chk_cfg("cap", 16'(c), 16'(o_cfg.feedback_cap_sel));
			chk_cfg("rin", (v == 0) ? 16'(AOTC_RIN_200K) : (v == 1) ? 16'(AOTC_RIN_100K)
				: 16'(AOTC_RIN_50K), 16'(o_cfg.integrator_rin));
			chk_cfg("integ", {11'h000, c, 2'(v)}, 16'(o_cfg.integrator_select));
			acc(1'b1, 1'b0, `AOTC_ADDR_FAST_BYP, 16'h0004 | 16'(v));
			idle();
			@(negedge i_ref_clk);
			chk_cfg("fast_ext", 16'(v == 1), 16'(o_cfg.fast_osc_external_select));
			chk_cfg("fast_field", 16'(v), 16'(o_cfg.fast_osc_bypass_field));
			acc(1'b1, 1'b0, `AOTC_ADDR_PATH, (v == 0) ? `AOTC_PATH_DIRECT : (v == 1)
				? 16'h1234 : `AOTC_PATH_FULL);
			idle();
			@(negedge i_ref_clk);
			chk_cfg("path_mode", (v == 0) ? 16'(AOTC_PATH_MODE_DIRECT) : (v == 1)
				? 16'(AOTC_PATH_MODE_OTHER) : 16'(AOTC_PATH_MODE_FULL), 16'(o_cfg.path_mode));
			chk_cfg("path_word", mdl[1], o_cfg.analog_path_select);
			acc(1'b1, 1'b0, `AOTC_ADDR_SLOW_OSC, 16'h3600 | {1'b0, v[0], 5'h00, v[0], v[0],
				1'b0, v[0] ? 6'h3F : 6'h00});
			idle();
			@(negedge i_ref_clk);
			chk_cfg("slow_bits", {12'h000, v[0], v[0], v[0], 1'b0},
				{12'h000, o_cfg.slow_osc_power_n, o_cfg.slow_osc_external_select,
				o_cfg.slow_osc_wide_range, 1'b0});
			chk_cfg("slow_trim", v[0] ? 16'h003F : 16'h0000, 16'(o_cfg.slow_osc_freq_trim));
			rnd_wr(3);
			rnd_wr(6);
			idle();
			@(negedge i_ref_clk);
			chk_cfg("emitter", 16'(mdl[3][11:7]), 16'(o_cfg.emitter_current_trim));
			chk_cfg("fast_trim", {1'b0, mdl[6][14:0]},
				{1'b0, o_cfg.fast_osc_tempco_trim, o_cfg.fast_osc_freq_trim});
			idle();
		end
		// Back-to-back writes, unmapped offsets, read and write together
		for (int k = 0; k < 7; k++) rnd_wr(k);
		acc(1'b1, 1'b1, 8'h15, 16'hFFFF);
		acc(1'b1, 1'b1, `AOTC_ADDR_LED, 16'h0F80);
		acc(1'b0, 1'b1, 8'h17, 16'h0000);
		// Write then read the same offset in the next cycle
		rnd_wr(4);
		acc(1'b0, 1'b1, `AOTC_ADDR_SLOW_OSC, 16'h0000);
		read_all();
		do_reset();
		read_all();
		repeat (3) idle();
		chk_cfg("pending reads", 16'h0000, 16'(exp_q.size()));
		end_of_test();
	end

	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge i_ref_clk);
		n_errors++;
		end_of_test();
	end

endmodule // aotc_regs_tb_top

/* File: rtl/aotc_map.svh */
// Register offsets, field positions and reset values of the trim and configuration bank
`ifndef AOTC_MAP_SVH
`define AOTC_MAP_SVH

// Register offsets on the internal register port
`define AOTC_ADDR_INTEG      8'h12
`define AOTC_ADDR_PATH       8'h13
`define AOTC_ADDR_REFBIAS    8'h14
`define AOTC_ADDR_LED        8'h16
`define AOTC_ADDR_SLOW_OSC   8'h18
`define AOTC_ADDR_FAST_BYP   8'h19
`define AOTC_ADDR_FAST_TRIM  8'h1A

// Whole-register reset values, reserved fields included
`define AOTC_RST_INTEG       16'h1C08
`define AOTC_RST_PATH        16'hADA5
`define AOTC_RST_REFBIAS     16'h0080
`define AOTC_RST_LED         16'h0600
`define AOTC_RST_SLOW_OSC    16'h3620
`define AOTC_RST_FAST_BYP    16'h0004
`define AOTC_RST_FAST_TRIM   16'h425E

// Field reset values
`define AOTC_RST_INTEG_FLD   5'h1C
`define AOTC_RST_LED_FLD     5'h0C
`define AOTC_RST_SLOW_TRIM   6'h20
`define AOTC_RST_FAST_VTRIM  8'h5E
`define AOTC_RST_FAST_RTRIM  7'h42

// Field positions
`define AOTC_INTEG_MSB       12
`define AOTC_INTEG_LSB       8
`define AOTC_CAP_MSB         12
`define AOTC_CAP_LSB         10
`define AOTC_RES_MSB         9
`define AOTC_RES_LSB         8
`define AOTC_LED_MSB         11
`define AOTC_LED_LSB         7
`define AOTC_SLOW_TRIM_MSB   5
`define AOTC_SLOW_TRIM_LSB   0
`define AOTC_SLOW_PWR_BIT    7
`define AOTC_SLOW_EXT_BIT    8
`define AOTC_SLOW_WIDE_BIT   14
`define AOTC_FAST_BYP_MSB    1
`define AOTC_FAST_BYP_LSB    0
`define AOTC_VTRIM_MSB       7
`define AOTC_VTRIM_LSB       0
`define AOTC_RTRIM_MSB       14
`define AOTC_RTRIM_LSB       8

// Path selection codes and the external-clock bypass code
`define AOTC_PATH_FULL       16'hADA5
`define AOTC_PATH_DIRECT     16'hB065
`define AOTC_FAST_BYP_EXT    2'h1

`endif

/* File: rtl/aotc_pkg.sv */
// Types shared by the trim and configuration bank
package aotc_pkg;

	// Integrator input resistor choice
	typedef enum logic [1:0] {
		AOTC_RIN_200K,
		AOTC_RIN_100K,
		AOTC_RIN_50K
	} aotc_rin_e;

	// Analog chain routing
	typedef enum logic [1:0] {
		AOTC_PATH_MODE_FULL,
		AOTC_PATH_MODE_DIRECT,
		AOTC_PATH_MODE_OTHER
	} aotc_path_e;

	// Decoded settings handed to the analog blocks
	typedef struct packed {
		logic [2:0]  feedback_cap_sel;
		aotc_rin_e   integrator_rin;
		logic [4:0]  integrator_select;
		logic [15:0] analog_path_select;
		aotc_path_e  path_mode;
		logic [15:0] reference_bias;
		logic [4:0]  emitter_current_trim;
		logic [5:0]  slow_osc_freq_trim;
		logic        slow_osc_power_n;
		logic        slow_osc_external_select;
		logic        slow_osc_wide_range;
		logic [1:0]  fast_osc_bypass_field;
		logic        fast_osc_external_select;
		logic [7:0]  fast_osc_freq_trim;
		logic [6:0]  fast_osc_tempco_trim;
	} aotc_cfg_s;

endpackage : aotc_pkg

/* File: rtl/aotc_regs.sv */
// Analog front end, emitter and oscillator trim register bank
// Behaviour
// - The integrator field is bits 12:8, reset 0x1C; its top bits add 3.62, 1.81 and 0.9 pF.
// - The two low integrator bits pick the input resistor: 0 is 200k, 1 is 100k, 2 or 3 is 50k.
// - Path value 0xADA5, the reset, runs the full chain; 0xB065 links transimpedance to ADC.
// - The emitter current trim lives in bits 11:7 and resets to 0xC.
// - The slow oscillator trim is bits 5:0, reset 0x20, with 0x00 fastest and 0x3F slowest.
// - Slow oscillator bit 7 is active-low power control, reset 0, which keeps it powered up.
// - Slow oscillator bit 8 set swaps the internal slow oscillator for the external test clock.
// - Slow oscillator bit 14, reset to 0, widens the frequency range when set.
// - Fast bypass field bits 1:0 reset to 0; value 1 takes the fast clock from the test clock.
// - The fast trim in bits 7:0 resets to 0x5E for the nominal 32 MHz.
// - The temperature compensation trim in bits 14:8 of the fast trim register resets to 0x42.
`include "aotc_map.svh"

module aotc_regs
	import aotc_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_wr_en,
	input  wire logic        i_rd_en,
	input  wire logic [7:0]  i_addr,
	input  wire logic [15:0] i_wr_data,
	output logic      [15:0] o_rd_data,
	output logic             o_rd_valid,
	output logic             o_rd_hit,
	output aotc_cfg_s        o_cfg
);

	localparam int NREGS = 7;

	logic [15:0] regs_reg [NREGS];
	logic [15:0] rd_data_reg;
	logic        rd_valid_reg;
	logic        rd_hit_reg;
	logic [2:0]  wr_idx;
	logic [2:0]  rd_idx;
	logic        wr_hit;
	logic        rd_hit;

	// Map an offset onto a storage index, NREGS when unmapped
	function automatic logic [2:0] addr_index(input logic [7:0] a);
		case (a)
			`AOTC_ADDR_INTEG:     addr_index = 3'h0;
			`AOTC_ADDR_PATH:      addr_index = 3'h1;
			`AOTC_ADDR_REFBIAS:   addr_index = 3'h2;
			`AOTC_ADDR_LED:       addr_index = 3'h3;
			`AOTC_ADDR_SLOW_OSC:  addr_index = 3'h4;
			`AOTC_ADDR_FAST_BYP:  addr_index = 3'h5;
			`AOTC_ADDR_FAST_TRIM: addr_index = 3'h6;
			default:              addr_index = 3'h7;
		endcase
	endfunction

	// Reset value of each stored register
	function automatic logic [15:0] reset_value(input logic [2:0] idx);
		case (idx)
			3'h0:    reset_value = `AOTC_RST_INTEG;
			3'h1:    reset_value = `AOTC_RST_PATH;
			3'h2:    reset_value = `AOTC_RST_REFBIAS;
			3'h3:    reset_value = `AOTC_RST_LED;
			3'h4:    reset_value = `AOTC_RST_SLOW_OSC;
			3'h5:    reset_value = `AOTC_RST_FAST_BYP;
			3'h6:    reset_value = `AOTC_RST_FAST_TRIM;
			default: reset_value = 16'h0000;
		endcase
	endfunction

	// Address decode for both directions
	assign wr_idx = addr_index(i_addr);
	assign rd_idx = addr_index(i_addr);
	assign wr_hit = i_wr_en && (wr_idx != 3'h7);
	assign rd_hit = i_rd_en && (rd_idx != 3'h7);

	// Register storage, reserved bits kept as written
	always_ff @(posedge i_ref_clk) begin
		for (int i = 0; i < NREGS; i++) begin
			if (i_sys_rst) begin
				regs_reg[i] <= reset_value(3'(i));
			end else if (wr_hit && (wr_idx == 3'(i))) begin
				regs_reg[i] <= i_wr_data;
			end
		end
	end

	// Registered read port, unmapped offsets read zero
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			rd_data_reg  <= 16'h0000;
			rd_valid_reg <= 1'b0;
			rd_hit_reg   <= 1'b0;
		end else begin
			rd_valid_reg <= i_rd_en;
			rd_hit_reg   <= rd_hit;
			if (rd_hit) begin
				rd_data_reg <= regs_reg[rd_idx];
			end else if (i_rd_en) begin
				rd_data_reg <= 16'h0000;
			end
		end
	end

	assign o_rd_data  = rd_data_reg;
	assign o_rd_valid = rd_valid_reg;
	assign o_rd_hit   = rd_hit_reg;

	// Integrator capacitor and resistor decode
	always_comb begin
		o_cfg = '0;
		o_cfg.integrator_select = regs_reg[0][`AOTC_INTEG_MSB:`AOTC_INTEG_LSB];
		o_cfg.feedback_cap_sel  = regs_reg[0][`AOTC_CAP_MSB:`AOTC_CAP_LSB];
		case (regs_reg[0][`AOTC_RES_MSB:`AOTC_RES_LSB])
			2'h0:    o_cfg.integrator_rin = AOTC_RIN_200K;
			2'h1:    o_cfg.integrator_rin = AOTC_RIN_100K;
			default: o_cfg.integrator_rin = AOTC_RIN_50K;
		endcase
		// Analog path routing
		o_cfg.analog_path_select = regs_reg[1];
		case (regs_reg[1])
			`AOTC_PATH_FULL:    o_cfg.path_mode = AOTC_PATH_MODE_FULL;
			`AOTC_PATH_DIRECT:  o_cfg.path_mode = AOTC_PATH_MODE_DIRECT;
			default:            o_cfg.path_mode = AOTC_PATH_MODE_OTHER;
		endcase
		o_cfg.reference_bias       = regs_reg[2];
		o_cfg.emitter_current_trim = regs_reg[3][`AOTC_LED_MSB:`AOTC_LED_LSB];
		// Slow oscillator controls
		o_cfg.slow_osc_freq_trim =
			regs_reg[4][`AOTC_SLOW_TRIM_MSB:`AOTC_SLOW_TRIM_LSB];
		o_cfg.slow_osc_power_n         = regs_reg[4][`AOTC_SLOW_PWR_BIT];
		o_cfg.slow_osc_external_select = regs_reg[4][`AOTC_SLOW_EXT_BIT];
		o_cfg.slow_osc_wide_range      = regs_reg[4][`AOTC_SLOW_WIDE_BIT];
		// Fast oscillator controls
		o_cfg.fast_osc_bypass_field = regs_reg[5][`AOTC_FAST_BYP_MSB:`AOTC_FAST_BYP_LSB];
		o_cfg.fast_osc_external_select =
			(o_cfg.fast_osc_bypass_field == `AOTC_FAST_BYP_EXT);
		o_cfg.fast_osc_freq_trim   = regs_reg[6][`AOTC_VTRIM_MSB:`AOTC_VTRIM_LSB];
		o_cfg.fast_osc_tempco_trim = regs_reg[6][`AOTC_RTRIM_MSB:`AOTC_RTRIM_LSB];
	end

	// Helper copies of the last request for the checks
	logic [15:0] wr_data_q;
	logic [7:0]  wr_addr_q;
	logic        wr_en_q;
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			wr_data_q <= 16'h0000;
			wr_addr_q <= 8'h00;
			wr_en_q   <= 1'b0;
		end else begin
			wr_data_q <= i_wr_data;
			wr_addr_q <= i_addr;
			wr_en_q   <= i_wr_en;
		end
	end

	// Checks on the decoded outputs and readback
	chk_integ_reset: assert property (@(posedge i_ref_clk)
		i_sys_rst |=> o_cfg.integrator_select == `AOTC_RST_INTEG_FLD
			&& o_cfg.feedback_cap_sel == 3'h7)
		else $error("integrator field wrong after reset");

	chk_rin_decode: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_wr_en && i_addr == `AOTC_ADDR_INTEG |=> o_cfg.integrator_rin
			== (wr_data_q[`AOTC_RES_MSB] ? AOTC_RIN_50K : wr_data_q[`AOTC_RES_LSB]
			? AOTC_RIN_100K : AOTC_RIN_200K))
		else $error("input resistor decode wrong");

	chk_path_mode: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_wr_en && i_addr == `AOTC_ADDR_PATH && i_wr_data == `AOTC_PATH_DIRECT
			|=> o_cfg.path_mode == AOTC_PATH_MODE_DIRECT)
		else $error("path write did not select direct mode");

	chk_led_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_wr_en && i_addr == `AOTC_ADDR_LED
			|=> o_cfg.emitter_current_trim == wr_data_q[`AOTC_LED_MSB:`AOTC_LED_LSB])
		else $error("emitter trim did not follow write");

	chk_slow_reset: assert property (@(posedge i_ref_clk)
		i_sys_rst |=> o_cfg.slow_osc_freq_trim == `AOTC_RST_SLOW_TRIM
			&& !o_cfg.slow_osc_power_n && !o_cfg.slow_osc_wide_range)
		else $error("slow oscillator defaults wrong");

	chk_slow_ctrl: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		wr_en_q && wr_addr_q == `AOTC_ADDR_SLOW_OSC
			|-> o_cfg.slow_osc_power_n == wr_data_q[`AOTC_SLOW_PWR_BIT]
			&& o_cfg.slow_osc_external_select == wr_data_q[`AOTC_SLOW_EXT_BIT]
			&& o_cfg.slow_osc_wide_range == wr_data_q[`AOTC_SLOW_WIDE_BIT])
		else $error("slow oscillator controls did not follow write");

	chk_fast_bypass: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_wr_en && i_addr == `AOTC_ADDR_FAST_BYP |=> o_cfg.fast_osc_external_select
			== (wr_data_q[`AOTC_FAST_BYP_MSB:`AOTC_FAST_BYP_LSB] == `AOTC_FAST_BYP_EXT))
		else $error("fast bypass decode wrong");

	chk_fast_reset: assert property (@(posedge i_ref_clk)
		i_sys_rst |=> o_cfg.fast_osc_freq_trim == `AOTC_RST_FAST_VTRIM
			&& o_cfg.fast_osc_tempco_trim == `AOTC_RST_FAST_RTRIM
			&& !o_cfg.fast_osc_external_select)
		else $error("fast oscillator defaults wrong");

	chk_readback: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_wr_en && addr_index(i_addr) != 3'h7 ##1 i_rd_en && i_addr == $past(i_addr)
			&& !i_wr_en |=> o_rd_valid && o_rd_data == $past(i_wr_data, 2))
		else $error("readback differs from last write");

	chk_unmapped_zero: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_rd_en && addr_index(i_addr) == 3'h7 |=> o_rd_valid && !o_rd_hit
			&& o_rd_data == 16'h0000)
		else $error("unmapped read not zero");

	// Main scenarios
	cov_direct_path: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_cfg.path_mode == AOTC_PATH_MODE_DIRECT);
	cov_slow_external: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_cfg.slow_osc_external_select && o_cfg.slow_osc_power_n);
	cov_fast_external: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_cfg.fast_osc_external_select);
	cov_write_read: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_wr_en ##1 i_rd_en ##1 o_rd_hit);

endmodule // aotc_regs
